// >>> rtl/sap_defines.svh
// Constants of the serial audio port: register map, field positions, codes, timing
// Assumes inclusion by bare name from the package and the design modules
`ifndef SAP_DEFINES_SVH
`define SAP_DEFINES_SVH

`define SAP_ADDR_SPC0    16'h4015
`define SAP_ADDR_SPC1    16'h4016
`define SAP_ADDR_CC0     16'h4017
`define SAP_ADDR_CC1     16'h4018
`define SAP_RST_VAL      8'h00
`define SAP_SPC0_MASK    8'h3f
`define SAP_CC0_MASK     8'h60
`define SAP_CC1_MASK     8'h03

`define SAP_B_MASTER     0
`define SAP_F_CPF        2:1
`define SAP_B_LRPOL      3
`define SAP_B_BPOL       4
`define SAP_B_LRMODE     5
`define SAP_F_DELAY      1:0
`define SAP_B_LSBF       2
`define SAP_B_DACORD     3
`define SAP_B_ADCORD     4
`define SAP_F_FLEN       7:5
`define SAP_F_DACPAIR    6:5
`define SAP_F_ADCPAIR    1:0

`define SAP_CPF_TDM4     2'h1
`define SAP_CPF_TDM8     2'h2
`define SAP_SH_STEREO    1
`define SAP_SH_TDM4      2
`define SAP_SH_TDM8      3
`define SAP_FLEN_32      3'h1
`define SAP_FLEN_48      3'h2
`define SAP_FLEN_128     3'h3
`define SAP_FLEN_256     3'h4
`define SAP_LEN_64       9'h040
`define SAP_LEN_32       9'h020
`define SAP_LEN_48       9'h030
`define SAP_LEN_128      9'h080
`define SAP_LEN_256      9'h100
`define SAP_DLY_0        2'h1
`define SAP_DLY_8        2'h2
`define SAP_DLY_16       2'h3
`define SAP_DVAL_1       5'h01
`define SAP_DVAL_0       5'h00
`define SAP_DVAL_8       5'h08
`define SAP_DVAL_16      5'h10

`define SAP_WORD_BITS    24
`define SAP_WORD_LAST    23
`define SAP_PIN_W        3
`define SAP_PIN_BCLK     0
`define SAP_PIN_LRCLK    1
`define SAP_PIN_SDIN     2
`define SAP_BUF_DEPTH    2
`define SAP_REF_NS       40
`define SAP_BCLK_NS      320
`define SAP_BCLK_HALF    ((`SAP_BCLK_NS) / (2 * `SAP_REF_NS))

`endif

// >>> rtl/sap_pkg.sv
// Types of the serial audio port
// Assumes sap_defines.svh is on the include path
`include "sap_defines.svh"
package sap_pkg;
   typedef struct packed {
      logic [`SAP_WORD_BITS-1:0] left;
      logic [`SAP_WORD_BITS-1:0] right;
   } sap_pair_s;

   typedef struct packed {
      logic       master;
      logic [1:0] cpf;
      logic       lrpol;
      logic       bpol;
      logic       lrmode;
      logic [1:0] dly;
      logic       lsbf;
      logic       dacord;
      logic       adcord;
      logic [2:0] flen;
      logic [1:0] dacpair;
      logic [1:0] adcpair;
   } sap_cfg_s;
endpackage

// >>> rtl/sap_sync.sv
// Two-flop synchroniser for the serial port pins
// Assumes inputs are asynchronous to ref_clk
`timescale 1ns/1ps
`include "sap_defines.svh"
module sap_sync (
   input  wire logic                  ref_clk,
   input  wire logic                  rstn,
   input  wire logic [`SAP_PIN_W-1:0] async_in,
   output logic      [`SAP_PIN_W-1:0] sync_out
);
   logic [`SAP_PIN_W-1:0] meta_ff;
   logic [`SAP_PIN_W-1:0] sync_ff;
   logic [`SAP_PIN_W-1:0] nxt_meta;
   logic [`SAP_PIN_W-1:0] nxt_sync;

   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_out = sync_ff;
endmodule

// >>> rtl/sap_buf.sv
// Two-entry sample pair buffer with valid and ready on both sides
// Assumes both sides on ref_clk; ready and valid are registered
`timescale 1ns/1ps
`include "sap_defines.svh"
module sap_buf (
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   input  wire logic               in_valid,
   output logic                    in_ready,
   input  wire sap_pkg::sap_pair_s in_data,
   output logic                    out_valid,
   input  wire logic               out_ready,
   output sap_pkg::sap_pair_s      out_data
);
   sap_pkg::sap_pair_s mem_ff  [`SAP_BUF_DEPTH];
   sap_pkg::sap_pair_s nxt_mem [`SAP_BUF_DEPTH];
   logic               wr_ff;
   logic               rd_ff;
   logic               rdy_ff;
   logic               vld_ff;
   logic [1:0]         cnt_ff;
   logic               nxt_wr;
   logic               nxt_rd;
   logic               nxt_rdy;
   logic               nxt_vld;
   logic [1:0]         nxt_cnt;
   logic               push;
   logic               pop;

   always_comb begin
      push    = in_valid && rdy_ff;
      pop     = out_ready && vld_ff;
      nxt_wr  = push ? !wr_ff : wr_ff;
      nxt_rd  = pop ? !rd_ff : rd_ff;
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
      nxt_rdy = (nxt_cnt != 2'h2);
      nxt_vld = (nxt_cnt != 2'h0);
   end

   for (genvar i = 0; i < `SAP_BUF_DEPTH; i++) begin : g_ent
      always_comb begin
         nxt_mem[i] = (push && (wr_ff == 1'(i))) ? in_data : mem_ff[i];
      end
      always_ff @(posedge ref_clk or negedge rstn) begin
         if (!rstn) begin
            mem_ff[i] <= '0;
         end else begin
            mem_ff[i] <= nxt_mem[i];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ff  <= 1'b0;
         rd_ff  <= 1'b0;
         cnt_ff <= 2'h0;
         rdy_ff <= 1'b1;
         vld_ff <= 1'b0;
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
         rdy_ff <= nxt_rdy;
         vld_ff <= nxt_vld;
      end
   end

   assign in_ready  = rdy_ff;
   assign out_valid = vld_ff;
   assign out_data  = mem_ff[rd_ff];
endmodule

// >>> rtl/sap_port.sv
// Serial audio port: control registers, bit and frame clock engine, slot mapping
// Assumes pins are asynchronous to ref_clk; sample pairs come from logic on ref_clk
// Function
// R1 - Frame clock mode: half duty or pulse
// R2 - Slave pulse lasts at least one bit clock
// R3 - Bit clock polarity picks data change edge
// R4 - Frame clock polarity picks left start edge
// R5 - Channels per frame: stereo, four, eight
// R6 - TDM output stays driven all frame
// R7 - Slots form left/right pairs, one pair used
// R8 - Port mode: master drives both clocks
// R9 - Frame length code sets bit clocks per frame
// R10 - Bit clock equals frame length times rate
// R11 - ADC pair order: left or right first
// R12 - DAC pair order: left or right first
// R13 - Pair select valid per TDM width
// R14 - Bit order: MSB or LSB first
// R15 - Data delay code: 1, 0, 8, 16
// R16 - Delay must keep word inside half frame
// R17 - All fields zero after reset
// R18 - Reserved codes are never written
// R19 - Launch on chosen edge, sample on other
`timescale 1ns/1ps
`include "sap_defines.svh"
module sap_port (
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   input  wire logic [15:0]        reg_addr,
   input  wire logic               reg_wr,
   input  wire logic [7:0]         reg_wdata,
   output logic      [7:0]         reg_rdata,
   input  wire logic               bit_clk_i,
   output logic                    bit_clk_o,
   output logic                    bit_clk_oe_n,
   input  wire logic               frame_clk_i,
   output logic                    frame_clk_o,
   output logic                    frame_clk_oe_n,
   input  wire logic               data_in,
   output logic                    data_out,
   input  wire logic               adc_valid,
   output logic                    adc_ready,
   input  wire sap_pkg::sap_pair_s adc_data,
   output logic                    dac_valid,
   output sap_pkg::sap_pair_s      dac_data
);
   logic [7:0]             spc0_ff;
   logic [7:0]             spc1_ff;
   logic [7:0]             cc0_ff;
   logic [7:0]             cc1_ff;
   logic [7:0]             rdata_ff;
   logic [7:0]             nxt_spc0;
   logic [7:0]             nxt_spc1;
   logic [7:0]             nxt_cc0;
   logic [7:0]             nxt_cc1;
   logic [7:0]             nxt_rdata;
   sap_pkg::sap_cfg_s      cfg;
   logic [8:0]             flen;
   logic [4:0]             dly;
   logic [7:0]             slot_w;
   logic [1:0]             adc_pair;
   logic [1:0]             dac_pair;
   logic                   adc_ord;
   logic                   dac_ord;
   logic [`SAP_PIN_W-1:0]  pin_s;
   logic                   bclk_prev_ff;
   logic                   lr_prev_ff;
   logic [2:0]             div_ff;
   logic                   bclk_o_ff;
   logic                   lr_o_ff;
   logic                   bclk_oe_n_ff;
   logic                   lr_oe_n_ff;
   logic [8:0]             cyc_ff;
   logic [7:0]             pos_ff;
   logic [2:0]             idx_ff;
   logic                   sdo_ff;
   sap_pkg::sap_pair_s     word_ff;
   sap_pkg::sap_pair_s     acc_ff;
   sap_pkg::sap_pair_s     dac_ff;
   logic                   dac_valid_ff;
   logic [2:0]             nxt_div;
   logic                   nxt_bclk_o;
   logic                   nxt_lr_o;
   logic                   nxt_oe_n;
   logic [8:0]             nxt_cyc;
   logic [7:0]             nxt_pos;
   logic [2:0]             nxt_idx;
   logic                   nxt_sdo;
   sap_pkg::sap_pair_s     nxt_word;
   sap_pkg::sap_pair_s     nxt_acc;
   sap_pkg::sap_pair_s     nxt_dac;
   logic                   nxt_dac_valid;
   logic                   edge_ev;
   logic                   edge_lvl;
   logic                   lr_start;
   logic                   launch;
   logic                   sample;
   logic                   frame_start;
   logic [5:0]             adc_hit;
   logic [5:0]             dac_hit;
   logic                   adc_sel;
   logic                   dac_sel;
   logic                   adc_right;
   logic                   dac_right;
   logic                   buf_valid;
   sap_pkg::sap_pair_s     buf_data;

   // Returns {hit, bit index} of the word bit carried at a slot position
   function automatic logic [5:0] word_bit(input logic [7:0] pos, input logic [4:0] d,
                                           input logic lsbf);
      logic [7:0] k;
      k = pos - {3'h0, d};
      if ((pos < {3'h0, d}) || (k >= 8'(`SAP_WORD_BITS))) begin
         word_bit = 6'h00;
      end else begin
         word_bit = {1'b1, lsbf ? k[4:0] : 5'(`SAP_WORD_LAST) - k[4:0]}; // R14
      end
   endfunction

   // Register file
   always_comb begin
      nxt_spc0 = spc0_ff;
      nxt_spc1 = spc1_ff;
      nxt_cc0  = cc0_ff;
      nxt_cc1  = cc1_ff;
      if (reg_wr) begin
         case (reg_addr)
            `SAP_ADDR_SPC0: nxt_spc0 = reg_wdata & `SAP_SPC0_MASK;
            `SAP_ADDR_SPC1: nxt_spc1 = reg_wdata;
            `SAP_ADDR_CC0:  nxt_cc0 = reg_wdata & `SAP_CC0_MASK;
            `SAP_ADDR_CC1:  nxt_cc1 = reg_wdata & `SAP_CC1_MASK;
            default:        nxt_spc0 = spc0_ff;
         endcase
      end
      case (reg_addr)
         `SAP_ADDR_SPC0: nxt_rdata = spc0_ff;
         `SAP_ADDR_SPC1: nxt_rdata = spc1_ff;
         `SAP_ADDR_CC0:  nxt_rdata = cc0_ff;
         `SAP_ADDR_CC1:  nxt_rdata = cc1_ff;
         default:        nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         spc0_ff  <= `SAP_RST_VAL; // R17
         spc1_ff  <= `SAP_RST_VAL; // R17
         cc0_ff   <= `SAP_RST_VAL;
         cc1_ff   <= `SAP_RST_VAL;
         rdata_ff <= 8'h00;
      end else begin
         spc0_ff  <= nxt_spc0;
         spc1_ff  <= nxt_spc1;
         cc0_ff   <= nxt_cc0;
         cc1_ff   <= nxt_cc1;
         rdata_ff <= nxt_rdata;
      end
   end

   // Field decode
   always_comb begin
      cfg.master  = spc0_ff[`SAP_B_MASTER];
      cfg.cpf     = spc0_ff[`SAP_F_CPF];
      cfg.lrpol   = spc0_ff[`SAP_B_LRPOL];
      cfg.bpol    = spc0_ff[`SAP_B_BPOL];
      cfg.lrmode  = spc0_ff[`SAP_B_LRMODE];
      cfg.dly     = spc1_ff[`SAP_F_DELAY];
      cfg.lsbf    = spc1_ff[`SAP_B_LSBF];
      cfg.dacord  = spc1_ff[`SAP_B_DACORD];
      cfg.adcord  = spc1_ff[`SAP_B_ADCORD];
      cfg.flen    = spc1_ff[`SAP_F_FLEN];
      cfg.dacpair = cc0_ff[`SAP_F_DACPAIR];
      cfg.adcpair = cc1_ff[`SAP_F_ADCPAIR];
      case (cfg.flen)
         `SAP_FLEN_32:  flen = `SAP_LEN_32; // R9
         `SAP_FLEN_48:  flen = `SAP_LEN_48;
         `SAP_FLEN_128: flen = `SAP_LEN_128;
         `SAP_FLEN_256: flen = `SAP_LEN_256;
         default:       flen = `SAP_LEN_64;
      endcase
      case (cfg.dly)
         `SAP_DLY_0:  dly = `SAP_DVAL_0; // R15
         `SAP_DLY_8:  dly = `SAP_DVAL_8;
         `SAP_DLY_16: dly = `SAP_DVAL_16;
         default:     dly = `SAP_DVAL_1;
      endcase
      case (cfg.cpf)
         `SAP_CPF_TDM4: begin // R5 R13
            slot_w   = 8'(flen >> `SAP_SH_TDM4);
            adc_pair = {1'b0, cfg.adcpair[0]};
            dac_pair = {1'b0, cfg.dacpair[0]};
            adc_ord  = cfg.adcord;
            dac_ord  = cfg.dacord;
         end
         `SAP_CPF_TDM8: begin // R5 R13
            slot_w   = 8'(flen >> `SAP_SH_TDM8);
            adc_pair = cfg.adcpair;
            dac_pair = cfg.dacpair;
            adc_ord  = cfg.adcord;
            dac_ord  = cfg.dacord;
         end
         default: begin // R5
            slot_w   = 8'(flen >> `SAP_SH_STEREO);
            adc_pair = 2'h0;
            dac_pair = 2'h0;
            adc_ord  = 1'b0;
            dac_ord  = 1'b0;
         end
      endcase
   end

   sap_sync u_sync (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .async_in ({data_in, frame_clk_i, bit_clk_i}),
      .sync_out (pin_s)
   );

   sap_buf u_buf (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .in_valid  (adc_valid),
      .in_ready  (adc_ready),
      .in_data   (adc_data),
      .out_valid (buf_valid),
      .out_ready (frame_start),
      .out_data  (buf_data)
   );

   // Clock engine, slot counters, serial data
   always_comb begin
      nxt_div = (div_ff == 3'(`SAP_BCLK_HALF - 1)) ? 3'h0 : div_ff + 3'h1;
      if (cfg.master) begin
         edge_ev  = (div_ff == 3'(`SAP_BCLK_HALF - 1)); // R10
         edge_lvl = !bclk_o_ff;
         lr_start = 1'b0;
      end else begin
         edge_ev  = (pin_s[`SAP_PIN_BCLK] != bclk_prev_ff);
         edge_lvl = pin_s[`SAP_PIN_BCLK];
         lr_start = (pin_s[`SAP_PIN_LRCLK] != lr_prev_ff) &&
                    (pin_s[`SAP_PIN_LRCLK] == cfg.lrpol); // R4
      end
      nxt_bclk_o = (cfg.master && edge_ev) ? edge_lvl : bclk_o_ff; // R8
      launch = edge_ev && (edge_lvl == cfg.bpol); // R3 R19
      sample = edge_ev && (edge_lvl != cfg.bpol); // R19
      frame_start = cfg.master ? (launch && (cyc_ff == flen - 9'h1)) : lr_start; // R10
      nxt_cyc = cyc_ff;
      nxt_pos = pos_ff;
      nxt_idx = idx_ff;
      if (frame_start) begin
         nxt_cyc = 9'h000;
         nxt_pos = 8'h00;
         nxt_idx = 3'h0;
      end else if (launch) begin
         nxt_cyc = cyc_ff + 9'h001;
         if (pos_ff == slot_w - 8'h01) begin // R7
            nxt_pos = 8'h00;
            nxt_idx = idx_ff + 3'h1;
         end else begin
            nxt_pos = pos_ff + 8'h01;
         end
      end
      nxt_lr_o = lr_o_ff;
      if (cfg.master && launch) begin
         if (cfg.lrmode) begin
            nxt_lr_o = (nxt_cyc == 9'h000) ? cfg.lrpol : !cfg.lrpol; // R1
         end else begin
            nxt_lr_o = (nxt_cyc < (flen >> 1)) ? cfg.lrpol : !cfg.lrpol; // R1 R4
         end
      end
      nxt_oe_n = !cfg.master; // R8
      nxt_word = word_ff;
      if (frame_start) begin
         nxt_word = buf_valid ? buf_data : '0;
      end
      adc_hit   = word_bit(nxt_pos, dly, cfg.lsbf);
      adc_sel   = (nxt_idx[2:1] == adc_pair); // R7 R13
      adc_right = nxt_idx[0] ^ adc_ord; // R11
      nxt_sdo   = sdo_ff;
      if (launch || frame_start) begin
         nxt_sdo = 1'b0; // R6
         if (adc_hit[5] && adc_sel) begin
            nxt_sdo = adc_right ? nxt_word.right[adc_hit[4:0]] : nxt_word.left[adc_hit[4:0]];
         end
      end
      dac_hit   = word_bit(pos_ff, dly, cfg.lsbf);
      dac_sel   = (idx_ff[2:1] == dac_pair); // R7 R13
      dac_right = idx_ff[0] ^ dac_ord; // R12
      nxt_acc   = acc_ff;
      if (sample && dac_hit[5] && dac_sel) begin // R19
         if (dac_right) begin
            nxt_acc.right[dac_hit[4:0]] = pin_s[`SAP_PIN_SDIN];
         end else begin
            nxt_acc.left[dac_hit[4:0]] = pin_s[`SAP_PIN_SDIN];
         end
      end
      nxt_dac       = frame_start ? acc_ff : dac_ff;
      nxt_dac_valid = frame_start;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bclk_prev_ff <= 1'b0;
         lr_prev_ff   <= 1'b0;
         div_ff       <= 3'h0;
         bclk_o_ff    <= 1'b0;
         lr_o_ff      <= 1'b0;
         bclk_oe_n_ff <= 1'b1;
         lr_oe_n_ff   <= 1'b1;
         cyc_ff       <= 9'h000;
         pos_ff       <= 8'h00;
         idx_ff       <= 3'h0;
         sdo_ff       <= 1'b0;
         word_ff      <= '0;
         acc_ff       <= '0;
         dac_ff       <= '0;
         dac_valid_ff <= 1'b0;
      end else begin
         bclk_prev_ff <= pin_s[`SAP_PIN_BCLK];
         lr_prev_ff   <= pin_s[`SAP_PIN_LRCLK];
         div_ff       <= nxt_div;
         bclk_o_ff    <= nxt_bclk_o;
         lr_o_ff      <= nxt_lr_o;
         bclk_oe_n_ff <= nxt_oe_n;
         lr_oe_n_ff   <= nxt_oe_n;
         cyc_ff       <= nxt_cyc;
         pos_ff       <= nxt_pos;
         idx_ff       <= nxt_idx;
         sdo_ff       <= nxt_sdo;
         word_ff      <= nxt_word;
         acc_ff       <= nxt_acc;
         dac_ff       <= nxt_dac;
         dac_valid_ff <= nxt_dac_valid;
      end
   end

   assign reg_rdata      = rdata_ff;
   assign bit_clk_o      = bclk_o_ff;
   assign bit_clk_oe_n   = bclk_oe_n_ff;
   assign frame_clk_o    = lr_o_ff;
   assign frame_clk_oe_n = lr_oe_n_ff;
   assign data_out       = sdo_ff;
   assign dac_valid      = dac_valid_ff;
   assign dac_data       = dac_ff;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_oe_master;
      (cfg.master && $past(cfg.master)) |-> (!bclk_oe_n_ff && !lr_oe_n_ff);
   endproperty
   a_oe_master: assert property (p_oe_master) else $error("master not driving clocks"); // R8

   property p_oe_slave;
      (!cfg.master && !$past(cfg.master)) |-> (bclk_oe_n_ff && lr_oe_n_ff);
   endproperty
   a_oe_slave: assert property (p_oe_slave) else $error("slave driving clocks"); // R8

   property p_bclk_half;
      disable iff (!rstn || !cfg.master)
      $changed(bclk_o_ff) |=> (!$changed(bclk_o_ff))[*3] ##1 $changed(bclk_o_ff);
   endproperty
   a_bclk_half: assert property (p_bclk_half) else $error("bit clock half period wrong"); // R10

   property p_frame_len;
      (cfg.master && frame_start) |-> (cyc_ff == flen - 9'h1);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length mismatch"); // R9

   property p_pulse;
      (cfg.master && cfg.lrmode && $changed(cyc_ff) && $stable(spc0_ff)) |->
         ((lr_o_ff == cfg.lrpol) == (cyc_ff == 9'h000));
   endproperty
   a_pulse: assert property (p_pulse) else $error("frame pulse misplaced"); // R1

   property p_half_duty;
      (cfg.master && !cfg.lrmode && $changed(cyc_ff) && $stable({spc0_ff, spc1_ff})) |->
         ((lr_o_ff == cfg.lrpol) == (cyc_ff < (flen >> 1)));
   endproperty
   a_half_duty: assert property (p_half_duty) else $error("frame clock duty wrong"); // R4

   property p_slave_start;
      (!cfg.master && lr_start) |=> ((cyc_ff == 9'h000) && (pos_ff == 8'h00));
   endproperty
   a_slave_start: assert property (p_slave_start) else $error("frame start missed"); // R4

   property p_launch_only;
      $changed(sdo_ff) |-> $past(launch || frame_start);
   endproperty
   a_launch_only: assert property (p_launch_only) else $error("data changed off edge"); // R19

   property p_pair_only;
      sdo_ff |-> (idx_ff[2:1] == adc_pair);
   endproperty
   a_pair_only: assert property (p_pair_only) else $error("data outside pair"); // R7

   property p_dac_pulse;
      dac_valid_ff |-> ($past(frame_start) ##1 !dac_valid_ff);
   endproperty
   a_dac_pulse: assert property (p_dac_pulse) else $error("dac valid not a pulse"); // R12

   property p_reset_zero;
      !$past(rstn) |-> ((spc0_ff == 8'h00) && (spc1_ff == 8'h00));
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("fields not zero"); // R17
endmodule

// >>> dv/sap_host.sv
// Host-side serial port model: clock master driving bit clock, frame clock and data
// Assumes the device is slave, stereo, 64 bit clocks per frame, polarities 0
`timescale 1ns/1ps
module sap_host (
   input  wire logic        run,
   input  wire logic [7:0]  cfg,
   input  wire logic [47:0] tx,
   input  wire logic        sdi,
   output logic             bclk,
   output logic             fclk,
   output logic             sdo,
   output logic [63:0]      rx,
   output logic             fdone
);
   int k;
   int b;
   initial begin
      bclk = 1'b1;
      fclk = 1'b1;
      sdo = 1'b0;
      rx = '0;
      fdone = 1'b0;
      forever begin
         wait (run);
         for (int n = 0; n < 64; n++) begin
            #160 bclk = 1'b0;
            fclk = (n >= 32);
            k = n % 32 - ((cfg[1:0] == 2'h1) ? 0 : 1);
            b = (n < 32 ? 24 : 0) + (cfg[2] ? k : 23 - k);
            sdo = (k >= 0 && k < 24) ? tx[b] : 1'b0;
            #160 bclk = 1'b1;
            rx = {rx[62:0], sdi};
         end
         fdone = ~fdone;
         #1;
         if (!run)
            sdo = ~sdo;
      end
   end
endmodule

// >>> dv/sap_port_test.sv
// Self-checking bench of the serial audio port against a host-side model
// Assumes a 25 MHz ref_clk and a 320 ns link bit clock from the host
`timescale 1ns/1ps
module sap_port_test;
   logic ref_clk, rstn, reg_wr, run, ok, dac_valid, adc_valid, adc_ready, data_out, fdone;
   logic bit_clk_o, bit_clk_oe_n, frame_clk_o, frame_clk_oe_n, h_bclk, h_fclk, h_sdo;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, cfg;
   logic [47:0] tx, p, last_dac, exp_p;
   logic [63:0] rx;
   logic [31:0] seed = 32'h0001_6a3a;
   sap_pkg::sap_pair_s adc_data, dac_data;
   logic [47:0] q[$];
   int failures = 0, total_checks = 0, cyc = 0, n, acc;
   logic [15:0] ra[5] = '{16'h4015, 16'h4016, 16'h4017, 16'h4018, 16'h4019};
   logic [7:0]  wv[5] = '{8'hfc, 8'h9f, 8'hff, 8'hff, 8'hff};
   logic [7:0]  rv[5] = '{8'h3c, 8'h9f, 8'h60, 8'h03, 8'h00};

   sap_port u_sap_port (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .bit_clk_i(bit_clk_oe_n ? h_bclk : bit_clk_o), .bit_clk_o(bit_clk_o),
      .bit_clk_oe_n(bit_clk_oe_n), .frame_clk_i(frame_clk_oe_n ? h_fclk : frame_clk_o),
      .frame_clk_o(frame_clk_o), .frame_clk_oe_n(frame_clk_oe_n), .data_in(h_sdo),
      .data_out(data_out), .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data(adc_data),
      .dac_valid(dac_valid), .dac_data(dac_data));
   sap_host u_sap_host (.run(run), .cfg(cfg), .tx(tx), .sdi(data_out), .bclk(h_bclk),
      .fclk(h_fclk), .sdo(h_sdo), .rx(rx), .fdone(fdone));

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (dac_valid === 1'b1)
         last_dac <= dac_data;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end

   function automatic logic [23:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[23:0];
   endfunction

   function automatic logic [63:0] frame_exp(logic [47:0] w, logic [7:0] c);
      logic [63:0] f;
      int k;
      f = '0;
      for (int i = 0; i < 64; i++) begin
         k = i % 32 - ((c[1:0] == 2'h1) ? 0 : 1);
         if (k >= 0 && k < 24)
            f[63-i] = w[(i < 32 ? 24 : 0) + (c[2] ? k : 23 - k)];
      end
      return f;
   endfunction

   task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   task rd(input logic [15:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      reg_addr = a;
      repeat (2) @(negedge ref_clk);
      chk("reg_rdata", reg_rdata, e);
   endtask

   task push(input logic [47:0] d, output logic taken);
      @(negedge ref_clk);
      adc_valid = 1'b1;
      adc_data = d;
      taken = adc_ready;
      @(negedge ref_clk);
      adc_valid = 1'b0;
   endtask

   task span(input logic fr, input logic lvl, output int c);
      c = 0;
      while ((fr ? frame_clk_o : bit_clk_o) === lvl) @(negedge ref_clk);
      while ((fr ? frame_clk_o : bit_clk_o) !== lvl) @(negedge ref_clk);
      while ((fr ? frame_clk_o : bit_clk_o) === lvl) begin
         c++;
         @(negedge ref_clk);
      end
   endtask

   task report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      {reg_addr, reg_wr, reg_wdata, adc_valid, adc_data, run, cfg, tx} = '0;
      repeat (8) @(negedge ref_clk);
      rstn = 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(ra[i], 8'h00);
         wr(ra[i], wv[i]);
         rd(ra[i], rv[i]);
         wr(ra[i], 8'h00);
      end
      $display("test registers done");
      acc = 0;
      for (int i = 0; i < 3; i++) begin
         p = {rnd(), rnd()};
         push(p, ok);
         if (ok === 1'b1) begin
            acc++;
            q.push_back(p);
         end
      end
      chk("buffer_fill", 64'(acc), 64'h2);
      $display("test buffer done");
      for (int it = 0; it < 2; it++) begin
         cfg = it ? 8'h05 : 8'h00;
         wr(16'h4016, cfg);
         if (it) begin
            p = {rnd(), rnd()};
            push(p, ok);
            q.push_back(p);
         end
         tx = {rnd(), rnd()};
         run = 1'b1;
         for (int f = 0; f < 2; f++) begin
            exp_p = q.size() ? q.pop_front() : '0;
            @(fdone);
            chk("adc_frame", rx, frame_exp(exp_p, cfg));
         end
         run = 1'b0;
         chk("dac_pair", last_dac, tx);
      end
      $display("test link done");
      wr(16'h4016, 8'h20);
      wr(16'h4015, 8'h01);
      repeat (2) @(negedge ref_clk);
      chk("oe_n", {bit_clk_oe_n, frame_clk_oe_n}, 2'b00);
      span(1'b0, 1'b0, n);
      chk("bclk_low", n, 4);
      span(1'b1, 1'b0, n);
      chk("fclk_half", n, 128);
      wr(16'h4016, 8'h40);
      repeat (2) span(1'b1, 1'b0, n);
      chk("fclk_half48", n, 192);
      wr(16'h4015, 8'h29);
      repeat (2) span(1'b1, 1'b1, n);
      chk("fclk_pulse", n, 8);
      wr(16'h4015, 8'h00);
      repeat (2) @(negedge ref_clk);
      chk("oe_n", {bit_clk_oe_n, frame_clk_oe_n}, 2'b11);
      $display("test master done");
      report_and_stop();
   end
endmodule
